//--- hdl/pin_stage.sv
`timescale 1ns/1ps

module pin_stage (
	// clock and reset
	input  wire logic mclk,
	input  wire logic resetn,
	// source selection
	input  wire logic owner,
	input  wire logic active_low,
	input  wire logic fault_force,
	input  wire logic fault_val,
	input  wire logic clim_force,
	input  wire logic clim_val,
	input  wire logic ovr_en,
	input  wire logic ovr_val,
	input  wire logic gen_val,
	input  wire logic gpio_val,
	// pin
	output logic      pin_q
);

	logic active_d;

	// fault over current limit over override over generator
	always_comb begin
		if (fault_force) begin
			active_d = fault_val;
		end else if (clim_force) begin
			active_d = clim_val;
		end else if (ovr_en) begin
			active_d = ovr_val;
		end else begin
			active_d = gen_val;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pin_q <= 1'b0;
		end else if (owner) begin
			pin_q <= active_d ^ active_low;
		end else begin
			pin_q <= gpio_val;
		end
	end

endmodule : pin_stage

//--- hdl/pwm_out_consts.svh
`ifndef PWM_OUT_CONSTS_SVH
`define PWM_OUT_CONSTS_SVH

// register byte offsets
`define OFS_TRIG_CTRL     5'h00
`define OFS_PIN_CTRL      5'h04
`define OFS_MODULE_CTRL   5'h08
`define OFS_IRQ_STATUS    5'h0C
`define OFS_IRQ_MASK      5'h10
`define OFS_UNLOCK        5'h14
`define OFS_STATE         5'h18

// trigger_postscale_control fields
`define TRG_DIV_MSB       15
`define TRG_DIV_LSB       12
`define TRG_DLY_MSB       5
`define TRG_DLY_LSB       0
`define TRG_WRITE_MASK    16'hF03F
`define TRG_RESET         16'h0000

// output_pin_control fields
`define PIN_OWN_H         15
`define PIN_OWN_L         14
`define PIN_POL_H         13
`define PIN_POL_L         12
`define PIN_PAIR_MSB      11
`define PIN_PAIR_LSB      10
`define PIN_OVREN_H       9
`define PIN_OVREN_L       8
`define PIN_OVR_H         7
`define PIN_OVR_L         6
`define PIN_FLT_H         5
`define PIN_FLT_L         4
`define PIN_CL_H          3
`define PIN_CL_L          2
`define PIN_SWAP          1
`define PIN_OVR_SYNC      0
`define PIN_RESET         16'hC000

// module control bits
`define CTL_MASTER_EN     0
`define CTL_FAULT_EN      1
`define CTL_CLIM_EN       2
`define CTL_WIDTH         3
`define CTL_RESET         3'h0

// interrupt status / mask bits
`define IRQ_TRIGGER       0
`define IRQ_FAULT         1
`define IRQ_CLIM          2
`define IRQ_LOCKED_WRITE  3
`define IRQ_WIDTH         4
`define IRQ_RESET         4'h0

// unlock keys, written in this order to the unlock register
`define UNLOCK_KEY1       8'h55
`define UNLOCK_KEY2       8'hAA

`endif

//--- hdl/pwm_out_pkg.sv
package pwm_out_pkg;

	typedef enum logic [1:0] {
		pair_complementary,
		pair_redundant,
		pair_push_pull,
		pair_reserved
	} pair_mode_t;

	typedef enum logic [1:0] {
		trig_idle,
		trig_delay,
		trig_run
	} trig_state_t;

endpackage : pwm_out_pkg

//--- hdl/pwm_output_trigger_control.sv
// Behaviour
// - one trigger out per divider-plus-one events
// - wait start-delay PWM cycles after enable
// - secondary generator never raises trigger interrupts
// - ownership bits pick PWM or GPIO, reset one
// - polarity bit set makes pin active low
// - pair mode: complementary, redundant, push-pull
// - override enable drives pin from override value
// - enabled fault forces pins to fault value
// - enabled current limit forces current-limit value
// - locked pin control writable only after unlock
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pwm_out_consts.svh"

module pwm_output_trigger_control #(
	parameter int IS_PRIMARY = 1,
	parameter int ADDR_W     = 5
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// generator and time base
	input  wire logic              gen_high,
	input  wire logic              gen_low,
	input  wire logic              pwm_cycle_start,
	input  wire logic              trigger_event,
	// protection inputs and configuration
	input  wire logic              fault_active,
	input  wire logic              current_limit_active,
	input  wire logic              write_lock_config,
	// gpio values used when the pwm does not own a pin
	input  wire logic              gpio_high,
	input  wire logic              gpio_low,
	// outputs
	output logic                   high_side_pin,
	output logic                   low_side_pin,
	output logic                   trigger_out,
	output logic                   irq
);

	if (IS_PRIMARY != 0 && IS_PRIMARY != 1) begin : g_bad_primary
		$error("IS_PRIMARY must be 0 or 1");
	end
	if (ADDR_W < 5) begin : g_bad_addr_w
		$error("ADDR_W must be at least 5");
	end

	localparam logic IS_PRIMARY_BIT = (IS_PRIMARY != 0);

	logic [15:0]              trigger_postscale_control_q;
	logic [15:0]              output_pin_control_q;
	logic [`CTL_WIDTH-1:0]    ctrl_q;
	logic [`IRQ_WIDTH-1:0]    status_q;
	logic [`IRQ_WIDTH-1:0]    mask_q;
	logic                     key1_seen_q;
	logic                     unlocked_q;
	logic                     ack_q;
	logic [31:0]              rdata_d;
	logic                     wr_take;
	logic                     rd_take;
	logic                     pin_ctrl_wr;
	logic                     pin_ctrl_refused;
	logic [`IRQ_WIDTH-1:0]    events;
	logic [`IRQ_WIDTH-1:0]    clear_bits;
	logic                     pwm_master_enable;
	logic                     fault_force;
	logic                     clim_force;
	logic                     fault_force_q;
	logic                     clim_force_q;

	pwm_out_pkg::trig_state_t trig_state_q;
	logic [5:0]               delay_cnt_q;
	logic [3:0]               event_cnt_q;
	logic [3:0]               trigger_divide_field;
	logic [5:0]               trigger_start_delay;

	pwm_out_pkg::pair_mode_t  pair_mode;
	logic                     push_phase_q;
	logic                     ovr_en_h_q;
	logic                     ovr_en_l_q;
	logic                     ovr_val_h_q;
	logic                     ovr_val_l_q;
	logic                     src_h;
	logic                     src_l;
	logic                     drive_h;
	logic                     drive_l;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
						input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : merge16

	// bus handshake: every access answers on the second edge
	assign wr_take         = avs_write & ack_q;
	assign rd_take         = avs_read & ack_q;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	assign pin_ctrl_wr      = wr_take && (avs_address[4:0] == `OFS_PIN_CTRL);
	assign pin_ctrl_refused = pin_ctrl_wr && write_lock_config && !unlocked_q;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			trigger_postscale_control_q <= `TRG_RESET;
			ctrl_q                      <= `CTL_RESET;
			mask_q                      <= `IRQ_RESET;
		end else if (wr_take) begin
			case (avs_address[4:0])
				`OFS_TRIG_CTRL: begin
					trigger_postscale_control_q <= merge16(trigger_postscale_control_q,
						avs_writedata, avs_byteenable) & `TRG_WRITE_MASK;
				end
				`OFS_MODULE_CTRL: begin
					if (avs_byteenable[0]) begin
						ctrl_q <= avs_writedata[`CTL_WIDTH-1:0];
					end
				end
				`OFS_IRQ_MASK: begin
					if (avs_byteenable[0]) begin
						mask_q <= avs_writedata[`IRQ_WIDTH-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// pin control guarded by the write lock
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			output_pin_control_q <= `PIN_RESET;
		end else if (pin_ctrl_wr && !pin_ctrl_refused) begin
			output_pin_control_q <= merge16(output_pin_control_q, avs_writedata,
				avs_byteenable);
		end
	end

	// two-key unlock; it opens exactly one pin control write
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			key1_seen_q <= 1'b0;
			unlocked_q  <= 1'b0;
		end else if (wr_take) begin
			if (avs_address[4:0] == `OFS_UNLOCK && avs_byteenable[0]) begin
				key1_seen_q <= (avs_writedata[7:0] == `UNLOCK_KEY1);
				unlocked_q  <= key1_seen_q && (avs_writedata[7:0] == `UNLOCK_KEY2);
			end else begin
				key1_seen_q <= 1'b0;
				if (pin_ctrl_wr) begin
					unlocked_q <= 1'b0;
				end
			end
		end
	end

	// read mux, registered while waitrequest is high
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (avs_address[4:0])
			`OFS_TRIG_CTRL:   rdata_d[15:0] = trigger_postscale_control_q;
			`OFS_PIN_CTRL:    rdata_d[15:0] = output_pin_control_q;
			`OFS_MODULE_CTRL: rdata_d[`CTL_WIDTH-1:0] = ctrl_q;
			`OFS_IRQ_STATUS:  rdata_d[`IRQ_WIDTH-1:0] = status_q;
			`OFS_IRQ_MASK:    rdata_d[`IRQ_WIDTH-1:0] = mask_q;
			`OFS_UNLOCK:      rdata_d[1:0] = {unlocked_q, key1_seen_q};
			`OFS_STATE:       rdata_d[15:0] = {trig_state_q, event_cnt_q, delay_cnt_q,
						push_phase_q, fault_force_q, clim_force_q, 1'b0};
			default:          rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			avs_readdata <= rdata_d;
		end
	end

	assign pwm_master_enable    = ctrl_q[`CTL_MASTER_EN];
	assign trigger_divide_field = trigger_postscale_control_q[`TRG_DIV_MSB:`TRG_DIV_LSB];
	assign trigger_start_delay  = trigger_postscale_control_q[`TRG_DLY_MSB:`TRG_DLY_LSB];

	// start delay in pwm cycles, then postscaled triggers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			trig_state_q <= pwm_out_pkg::trig_idle;
			delay_cnt_q  <= 6'h00;
		end else begin
			case (trig_state_q)
				pwm_out_pkg::trig_idle: begin
					delay_cnt_q <= trigger_start_delay;
					if (pwm_master_enable) begin
						trig_state_q <= (trigger_start_delay == 6'h00) ?
							pwm_out_pkg::trig_run : pwm_out_pkg::trig_delay;
					end
				end
				pwm_out_pkg::trig_delay: begin
					if (!pwm_master_enable) begin
						trig_state_q <= pwm_out_pkg::trig_idle;
					end else if (pwm_cycle_start) begin
						delay_cnt_q <= delay_cnt_q - 6'h01;
						if (delay_cnt_q == 6'h01) begin
							trig_state_q <= pwm_out_pkg::trig_run;
						end
					end
				end
				pwm_out_pkg::trig_run: begin
					if (!pwm_master_enable) begin
						trig_state_q <= pwm_out_pkg::trig_idle;
					end
				end
				default: begin
					trig_state_q <= pwm_out_pkg::trig_idle;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			event_cnt_q <= 4'h0;
			trigger_out <= 1'b0;
		end else if (trig_state_q != pwm_out_pkg::trig_run || !pwm_master_enable) begin
			event_cnt_q <= 4'h0;
			trigger_out <= 1'b0;
		end else if (trigger_event) begin
			if (event_cnt_q >= trigger_divide_field) begin
				event_cnt_q <= 4'h0;
				trigger_out <= 1'b1;
			end else begin
				event_cnt_q <= event_cnt_q + 4'h1;
				trigger_out <= 1'b0;
			end
		end else begin
			trigger_out <= 1'b0;
		end
	end

	// protection forcing and its rising edges for the status register
	assign fault_force = fault_active && ctrl_q[`CTL_FAULT_EN];
	assign clim_force  = current_limit_active && ctrl_q[`CTL_CLIM_EN];

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			fault_force_q <= 1'b0;
			clim_force_q  <= 1'b0;
		end else begin
			fault_force_q <= fault_force;
			clim_force_q  <= clim_force;
		end
	end

	always_comb begin
		events                    = '0;
		events[`IRQ_TRIGGER]      = trigger_out && IS_PRIMARY_BIT;
		events[`IRQ_FAULT]        = fault_force && !fault_force_q;
		events[`IRQ_CLIM]         = clim_force && !clim_force_q;
		events[`IRQ_LOCKED_WRITE] = pin_ctrl_refused;
	end

	assign clear_bits = (wr_take && avs_address[4:0] == `OFS_IRQ_STATUS && avs_byteenable[0]) ?
		avs_writedata[`IRQ_WIDTH-1:0] : '0;

	// a new event wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			status_q <= `IRQ_RESET;
		end else begin
			status_q <= (status_q & ~clear_bits) | events;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	// override values either follow at once or wait for the cycle boundary
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ovr_en_h_q  <= 1'b0;
			ovr_en_l_q  <= 1'b0;
			ovr_val_h_q <= 1'b0;
			ovr_val_l_q <= 1'b0;
		end else if (!output_pin_control_q[`PIN_OVR_SYNC] || pwm_cycle_start) begin
			ovr_en_h_q  <= output_pin_control_q[`PIN_OVREN_H];
			ovr_en_l_q  <= output_pin_control_q[`PIN_OVREN_L];
			ovr_val_h_q <= output_pin_control_q[`PIN_OVR_H];
			ovr_val_l_q <= output_pin_control_q[`PIN_OVR_L];
		end
	end

	// push-pull alternates the active pin each pwm cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			push_phase_q <= 1'b0;
		end else if (!pwm_master_enable) begin
			push_phase_q <= 1'b0;
		end else if (pwm_cycle_start) begin
			push_phase_q <= ~push_phase_q;
		end
	end

	// pair mode is sampled live; changing it while running glitches the pins
	assign pair_mode = pwm_out_pkg::pair_mode_t'(
		output_pin_control_q[`PIN_PAIR_MSB:`PIN_PAIR_LSB]);
	assign src_h = output_pin_control_q[`PIN_SWAP] ? gen_low : gen_high;
	assign src_l = output_pin_control_q[`PIN_SWAP] ? gen_high : gen_low;

	always_comb begin
		case (pair_mode)
			pwm_out_pkg::pair_redundant: begin
				drive_h = src_h;
				drive_l = src_h;
			end
			pwm_out_pkg::pair_push_pull: begin
				drive_h = src_h && !push_phase_q;
				drive_l = src_h && push_phase_q;
			end
			pwm_out_pkg::pair_complementary: begin
				drive_h = src_h;
				drive_l = !src_h;
			end
			default: begin
				// reserved code falls back to independent drive
				drive_h = src_h;
				drive_l = src_l;
			end
		endcase
	end

	pin_stage u_high (
		.mclk        (mclk),
		.resetn      (resetn),
		.owner       (output_pin_control_q[`PIN_OWN_H]),
		.active_low  (output_pin_control_q[`PIN_POL_H]),
		.fault_force (fault_force),
		.fault_val   (output_pin_control_q[`PIN_FLT_H]),
		.clim_force  (clim_force),
		.clim_val    (output_pin_control_q[`PIN_CL_H]),
		.ovr_en      (ovr_en_h_q),
		.ovr_val     (ovr_val_h_q),
		.gen_val     (drive_h),
		.gpio_val    (gpio_high),
		.pin_q       (high_side_pin)
	);

	pin_stage u_low (
		.mclk        (mclk),
		.resetn      (resetn),
		.owner       (output_pin_control_q[`PIN_OWN_L]),
		.active_low  (output_pin_control_q[`PIN_POL_L]),
		.fault_force (fault_force),
		.fault_val   (output_pin_control_q[`PIN_FLT_L]),
		.clim_force  (clim_force),
		.clim_val    (output_pin_control_q[`PIN_CL_L]),
		.ovr_en      (ovr_en_l_q),
		.ovr_val     (ovr_val_l_q),
		.gen_val     (drive_l),
		.gpio_val    (gpio_low),
		.pin_q       (low_side_pin)
	);

endmodule : pwm_output_trigger_control

//--- verif/power_stage_model.sv
`timescale 1ns/1ps

module power_stage_model (
	// clock
	input  wire logic mclk,
	// gate drives
	input  wire logic high_side_pin,
	input  wire logic low_side_pin,
	// both switches of the leg on
	output logic      shoot_q
);
	// legal in redundant mode, a short in the others
	always_ff @(posedge mclk) begin
		shoot_q <= high_side_pin && low_side_pin;
	end
endmodule : power_stage_model

//--- verif/pwm_output_trigger_control_chk.sv
`timescale 1ns/1ps

module pwm_otc_chk #(
	parameter int ADDR_W = 5
) (
	// clock, reset, bus
	input wire logic              mclk,
	input wire logic              resetn,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_writedata,
	input wire logic [3:0]        avs_byteenable,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	// generator and protection
	input wire logic              gen_high,
	input wire logic              gen_low,
	input wire logic              pwm_cycle_start,
	input wire logic              trigger_event,
	input wire logic              fault_active,
	input wire logic              current_limit_active,
	input wire logic              write_lock_config,
	input wire logic              gpio_high,
	input wire logic              gpio_low,
	// outputs
	input wire logic              high_side_pin,
	input wire logic              low_side_pin,
	input wire logic              trigger_out,
	input wire logic              irq
);
	logic [15:0] pc, pc_q;
	logic [5:0]  td;
	logic [6:0]  dcnt;
	logic [2:0]  mc;
	logic        f_q, c_q, lk_q;
	wire wok = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'h3;
	wire f = fault_active && mc[1];
	wire c = current_limit_active && mc[2];
	// shadow is blind to unlocked writes, so pause until resynced
	wire st = pc == pc_q && !lk_q && !write_lock_config;
	wire calm = st && pc[15:14] == 2'h3 && !f && !f_q && !c && !c_q;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pc   <= 16'hC000;
			pc_q <= 16'hC000;
			td   <= 6'h00;
			mc   <= 3'h0;
			dcnt <= 7'h00;
			f_q  <= 1'h0;
			c_q  <= 1'h0;
			lk_q <= 1'h0;
		end else begin
			pc_q <= pc;
			f_q  <= f;
			c_q  <= c;
			lk_q <= write_lock_config || (lk_q && !(wok && avs_address == 5'h04));
			if (wok && !write_lock_config && avs_address == 5'h04) pc <= avs_writedata[15:0];
			if (wok && avs_address == 5'h00) td <= avs_writedata[5:0];
			if (wok && avs_address == 5'h08) mc <= avs_writedata[2:0];
			if (!mc[0]) dcnt <= 7'h00;
			else if (pwm_cycle_start && dcnt != 7'h7F) dcnt <= dcnt + 7'h01;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_trig_src;
		trigger_out |-> $past(trigger_event);
	endproperty
	a_trig_src: assert property (p_trig_src) else $error("trigger without event");
	property p_delay;
		mc[0] && {1'h0, td} > dcnt |-> !trigger_out;
	endproperty
	a_delay: assert property (p_delay) else $error("trigger during delay");
	property p_owner;
		st && !pc[15] |=> high_side_pin == $past(gpio_high);
	endproperty
	a_owner: assert property (p_owner) else $error("gpio not on pin");
	property p_pol;
		calm && !pc[11] && pc[9:8] == 2'h0 && !pc[1] |=> high_side_pin == $past(gen_high ^ pc[13]);
	endproperty
	a_pol: assert property (p_pol) else $error("high pin sense");
	property p_pair;
		calm && !pc[11] && !pc[8] && !pc[1] |=>
			low_side_pin == $past((pc[10] ? gen_high : !gen_high) ^ pc[12]);
	endproperty
	a_pair: assert property (p_pair) else $error("low pin pairing");
	property p_ovr;
		calm && pc[9] && !pc[0] |=> high_side_pin == $past(pc[7] ^ pc[13]);
	endproperty
	a_ovr: assert property (p_ovr) else $error("override value");
	property p_fault;
		st && pc[15:14] == 2'h3 && f && f_q |=>
			{high_side_pin, low_side_pin} == $past(pc[5:4] ^ pc[13:12]);
	endproperty
	a_fault: assert property (p_fault) else $error("fault value");
	property p_clim;
		st && pc[15:14] == 2'h3 && c && c_q && !f && !f_q |=>
			{high_side_pin, low_side_pin} == $past(pc[3:2] ^ pc[13:12]);
	endproperty
	a_clim: assert property (p_clim) else $error("limit value");
	c_trig: cover property (trigger_out);
	c_fault: cover property (f && f_q);
	c_lock: cover property (wok && write_lock_config);
endmodule : pwm_otc_chk

bind pwm_output_trigger_control pwm_otc_chk #(.ADDR_W(ADDR_W)) chk (.*);

//--- verif/test_pwm_output_trigger_control.sv
`timescale 1ns/1ps

module test_pwm_output_trigger_control;
	logic        mclk = 1'h0, resetn = 1'h0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'h0, avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        avs_waitrequest, gen_high = 1'h0, gen_low = 1'h0;
	logic        pwm_cycle_start = 1'h0, trigger_event = 1'h0;
	logic        fault_active = 1'h0, current_limit_active = 1'h0;
	logic        write_lock_config = 1'h0, gpio_high = 1'h1, gpio_low = 1'h0;
	logic        high_side_pin, low_side_pin, trigger_out, irq, irq2, shoot;
	logic [15:0] q;
	int          errors = 0, total_checks = 0, tcnt = 0, i;
	localparam logic [3:0]  DV[3] = '{4'h0, 4'h3, 4'hF};
	// last two: swapped inputs, then an override held back until the cycle boundary
	localparam logic [15:0] PC[11] = '{16'hC000, 16'hC000, 16'hC400, 16'hF400, 16'h0000,
		16'hC3C0, 16'hC3D8, 16'hC3D8, 16'hC3D8, 16'hC002, 16'hC341};
	localparam logic [2:0]  MC[11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h6, 3'h4,
		3'h0, 3'h0};
	// fault, limit, generator high
	localparam logic [2:0]  IN[11] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h2, 3'h6, 3'h6,
		3'h1, 3'h1};
	localparam logic [1:0]  EX[11] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h2, 2'h1, 2'h2,
		2'h1, 2'h2};

	pwm_output_trigger_control dut (.*);
	pwm_output_trigger_control #(.IS_PRIMARY(0)) dut2 (.avs_readdata(), .avs_waitrequest(),
		.high_side_pin(), .low_side_pin(), .trigger_out(), .irq(irq2), .*);
	power_stage_model ps (.mclk, .high_side_pin, .low_side_pin, .shoot_q(shoot));

	always #5 mclk = ~mclk;
	always @(posedge mclk) if (trigger_out === 1'h1) tcnt++;

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= w;
		avs_read <= !w;
		// read just after the edge, these are the values that stood at it
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata[15:0];
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge mclk);
	endtask : xfer
	task wr(input logic [4:0] a, input logic [15:0] d);
		xfer(1'h1, a, d);
	endtask : wr
	task rd(input logic [4:0] a, input logic [15:0] e, input string nm);
		xfer(1'h0, a, 16'h0000);
		chk(nm, e, q);
	endtask : rd
	task pul(input logic ev, input int n);
		repeat (n) begin
			if (ev) trigger_event <= 1'h1;
			else pwm_cycle_start <= 1'h1;
			@(posedge mclk);
			trigger_event <= 1'h0;
			pwm_cycle_start <= 1'h0;
			@(posedge mclk);
		end
	endtask : pul
	task settle;
		repeat (4) @(posedge mclk);
	endtask : settle
	task complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		#100000;
		errors++;
		complete_run();
	end

	initial begin
		repeat (16) @(posedge mclk);
		resetn <= 1'h1;
		@(posedge mclk);
		rd(5'h04, 16'hC000, "pin ctrl reset");
		rd(5'h00, 16'h0000, "trig reset");
		rd(5'h1C, 16'h0000, "unmapped");
		wr(5'h00, 16'hFFFF);
		rd(5'h00, 16'hF03F, "trig fields");
		$display("done registers");
		wr(5'h10, 16'h0001);
		for (i = 0; i < 3; i++) begin
			wr(5'h00, {DV[i], 12'h000});
			wr(5'h08, 16'h0001);
			tcnt = 0;
			pul(1'h1, 3 * DV[i] + 2);
			settle();
			chk("trig count", 16'h0002, 16'(tcnt));
			chk("irq primary", 16'h0001, {15'h0, irq});
			chk("irq secondary", 16'h0000, {15'h0, irq2});
			wr(5'h08, 16'h0000);
			wr(5'h0C, 16'h000F);
		end
		$display("done divider");
		wr(5'h00, 16'h0003);
		wr(5'h08, 16'h0001);
		tcnt = 0;
		pul(1'h1, 1);
		pul(1'h0, 2);
		pul(1'h1, 1);
		settle();
		chk("early trig", 16'h0000, 16'(tcnt));
		pul(1'h0, 1);
		pul(1'h1, 1);
		settle();
		chk("first trig", 16'h0001, 16'(tcnt));
		wr(5'h08, 16'h0000);
		$display("done delay");
		for (i = 0; i < 11; i++) begin
			wr(5'h04, PC[i]);
			wr(5'h08, {13'h0, MC[i]});
			{fault_active, current_limit_active, gen_high} <= IN[i];
			settle();
			chk("pins", {14'h0, EX[i]}, {14'h0, high_side_pin, low_side_pin});
		end
		{fault_active, current_limit_active, gen_high} <= 3'h1;
		wr(5'h04, 16'hC800);
		wr(5'h08, 16'h0001);
		settle();
		chk("push first", 16'h0002, {14'h0, high_side_pin, low_side_pin});
		pul(1'h0, 1);
		settle();
		chk("push second", 16'h0001, {14'h0, high_side_pin, low_side_pin});
		chk("leg short", 16'h0000, {15'h0, shoot});
		wr(5'h08, 16'h0000);
		$display("done pins");
		wr(5'h04, 16'hC000);
		wr(5'h0C, 16'h000F);
		write_lock_config <= 1'h1;
		wr(5'h04, 16'hC001);
		rd(5'h04, 16'hC000, "locked write");
		rd(5'h0C, 16'h0008, "refused flag");
		chk("irq masked", 16'h0000, {15'h0, irq});
		wr(5'h10, 16'h0008);
		settle();
		chk("irq raised", 16'h0001, {15'h0, irq});
		wr(5'h14, 16'h0055);
		wr(5'h14, 16'h00AA);
		wr(5'h04, 16'h4000);
		rd(5'h04, 16'h4000, "unlocked write");
		wr(5'h04, 16'hC000);
		rd(5'h04, 16'h4000, "relocked");
		wr(5'h0C, 16'h0008);
		settle();
		chk("irq cleared", 16'h0000, {15'h0, irq});
		write_lock_config <= 1'h0;
		wr(5'h04, 16'hC000);
		$display("done lock");
		complete_run();
	end
endmodule : test_pwm_output_trigger_control
